// File: core/ioc_pkg.sv
// package of constants and types for the i/o cell register path
package ioc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [3:0] IOC_CFG_OFS    = 4'h0;
   localparam logic [3:0] IOC_CMD_OFS    = 4'h4;
   localparam logic [3:0] IOC_STATUS_OFS = 4'h8;

   // command register bit positions
   localparam int IOC_CMD_COMMIT_BIT = 0;
   localparam int IOC_CMD_INIT_BIT   = 1;

   // input delay selections
   localparam logic [1:0] IOC_DELAY_NONE    = 2'h0;
   localparam logic [1:0] IOC_DELAY_PARTIAL = 2'h1;
   localparam logic [1:0] IOC_DELAY_FULL    = 2'h2;

   // cell configuration, one word
   typedef struct packed {
      logic       enhanced;
      logic       route_b_registered;
      logic       route_a_registered;
      logic       capture_clk_invert;
      logic       capture_enable;
      logic       skip_input_delay;
      logic [1:0] delay_select;
      logic       out_registered;
      logic       out_invert;
      logic       tristate_connected;
      logic       enable_connected;
      logic       enable_to_output;
      logic       enable_to_input;
      logic       out_init_set;
      logic       in_init_set;
      logic       out_clk_invert;
      logic       in_clk_invert;
      logic       in_latch_mode;
   } ioc_cfg_type;

   localparam int IOC_CFG_WIDTH = 19;
   // full delay, enable routed to both elements, everything else clear
   localparam logic [18:0] IOC_CFG_RESET = 19'h01060;

   // status word
   typedef struct packed {
      logic config_done;
      logic pad_level;
      logic capture_level;
      logic output_level;
      logic input_level;
   } ioc_status_type;

endpackage

// File: core/ioc_register_path.sv
// register path of one programmable i/o cell with an avalon-mm register slave
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
module ioc_register_path
   import ioc_pkg::*;
#(
   parameter int DELAY_TAPS = 2
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // pad side
   input  wire logic        pad_in,
   input  wire logic        input_side_clock,
   input  wire logic        output_side_clock,
   input  wire logic        global_init_pulse,
   output logic             pad_out,
   output logic             pad_oe,
   // core side
   input  wire logic        core_out_data,
   input  wire logic        core_tristate,
   input  wire logic        storage_clock_enable,
   output logic             routed_input_a,
   output logic             routed_input_b
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   ioc_cfg_type         shadow_q;
   ioc_cfg_type         cfg_q;
   ioc_status_type      status;
   logic                config_done_q;
   logic                ack_q;
   logic                commit_q;
   logic                sw_init_q;
   logic [2:0]          sync0_q;
   logic [2:0]          sync1_q;
   logic [DELAY_TAPS:0] tap_q;
   logic                delayed_pad;
   logic                init_now;
   ioc_cfg_type         init_cfg;
   logic                ick;
   logic                ick_prev_q;
   logic                ick_rise;
   logic                ock;
   logic                ock_prev_q;
   logic                ock_rise;
   logic                cap_open;
   logic                enable_level;
   logic                in_en;
   logic                out_en;
   logic                capture_q;
   logic                in_d;
   logic                in_q;
   logic                out_d;
   logic                out_q;
   logic                pad_out_q;
   logic                pad_oe_q;
   logic                route_a_q;
   logic                route_b_q;
   logic [31:0]         readdata_q;
   logic [31:0]         cfg_word;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle, then the answer
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata    = readdata_q;
   assign cfg_word        = {{(32 - IOC_CFG_WIDTH){1'b0}}, shadow_q};

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         readdata_q <= 32'h0000_0000;
      end else if (avs_read & ~ack_q) begin
         if (avs_address == IOC_CFG_OFS) begin
            readdata_q <= cfg_word;
         end else if (avs_address == IOC_STATUS_OFS) begin
            readdata_q <= {27'h000_0000, status};
         end else begin
            readdata_q <= 32'h0000_0000;
         end
      end
   end

   // shadow holds software writes until commit
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shadow_q <= ioc_cfg_type'(IOC_CFG_RESET);
      end else if (avs_write & ack_q & (avs_address == IOC_CFG_OFS)) begin
         if (avs_byteenable[0]) begin
            shadow_q[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            shadow_q[15:8] <= avs_writedata[15:8];
         end
         if (avs_byteenable[2]) begin
            shadow_q[18:16] <= avs_writedata[18:16];
         end
      end
   end

   // command strobes, one cycle each
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         commit_q  <= 1'b0;
         sw_init_q <= 1'b0;
      end else begin
         commit_q  <= avs_write & ack_q & (avs_address == IOC_CMD_OFS) & avs_byteenable[0]
                      & avs_writedata[IOC_CMD_COMMIT_BIT];
         sw_init_q <= avs_write & ack_q & (avs_address == IOC_CMD_OFS) & avs_byteenable[0]
                      & avs_writedata[IOC_CMD_INIT_BIT];
      end
   end

   // active configuration changes only at commit
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg_q         <= ioc_cfg_type'(IOC_CFG_RESET);
         config_done_q <= 1'b0;
      end else if (commit_q) begin
         cfg_q         <= shadow_q;
         config_done_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: pad, input clock, output clock
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync0_q <= 3'h0;
         sync1_q <= 3'h0;
      end else begin
         sync0_q <= {output_side_clock, input_side_clock, pad_in};
         sync1_q <= sync0_q;
      end
   end

   // global init is an async pin; its own two-stage catch
   logic init_s0_q;
   logic init_s1_q;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         init_s0_q <= 1'b0;
         init_s1_q <= 1'b0;
      end else begin
         init_s0_q <= global_init_pulse;
         init_s1_q <= init_s0_q;
      end
   end

   // commit also initialises, so elements start from their configured value
   assign init_now = init_s1_q | sw_init_q | commit_q;
   // a commit loads the values of the word it installs, not of the one it replaces
   assign init_cfg = commit_q ? shadow_q : cfg_q;

   ////////////////////////////////////////////////////////////////////////////
   // input delay line, one tap per ref_clk cycle
   assign tap_q[0] = sync1_q[0];
   genvar gi;
   generate
      for (gi = 1; gi <= DELAY_TAPS; gi++) begin : g_tap
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               tap_q[gi] <= 1'b0;
            end else begin
               tap_q[gi] <= tap_q[gi-1];
            end
         end
      end
   endgenerate

   // base variant has a single tap: any nonzero choice inserts it
   always_comb begin
      delayed_pad = tap_q[0];
      if (cfg_q.skip_input_delay || cfg_q.delay_select == IOC_DELAY_NONE) begin
         delayed_pad = tap_q[0];
      end else if (!cfg_q.enhanced || cfg_q.delay_select == IOC_DELAY_PARTIAL) begin
         delayed_pad = tap_q[1];
      end else begin
         delayed_pad = tap_q[DELAY_TAPS];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock polarity and edge detection
   assign ick      = sync1_q[1] ^ cfg_q.in_clk_invert;
   assign ock      = sync1_q[2] ^ cfg_q.out_clk_invert;
   assign cap_open = ~(sync1_q[2] ^ cfg_q.capture_clk_invert);
   assign ick_rise = ick & ~ick_prev_q;
   assign ock_rise = ock & ~ock_prev_q;

   // a commit that flips the polarity must not look like a clock edge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ick_prev_q <= 1'b0;
      end else if (commit_q) begin
         ick_prev_q <= sync1_q[1] ^ shadow_q.in_clk_invert;
      end else begin
         ick_prev_q <= ick;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ock_prev_q <= 1'b0;
      end else if (commit_q) begin
         ock_prev_q <= sync1_q[2] ^ shadow_q.out_clk_invert;
      end else begin
         ock_prev_q <= ock;
      end
   end

   // shared enable, never inverted, high when left unconnected
   assign enable_level = ~cfg_q.enable_connected | storage_clock_enable;
   assign in_en        = ~cfg_q.enable_to_input | enable_level;
   assign out_en       = ~cfg_q.enable_to_output | enable_level;

   ////////////////////////////////////////////////////////////////////////////
   // fast capture latch, transparent low on the output clock
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         capture_q <= 1'b0;
      end else if (init_now) begin
         capture_q <= init_cfg.in_init_set;
      end else if (config_done_q && cap_open) begin
         capture_q <= delayed_pad;
      end
   end

   assign in_d = (cfg_q.enhanced & cfg_q.capture_enable) ? capture_q : delayed_pad;

   ////////////////////////////////////////////////////////////////////////////
   // input storage element; latch follows d one ref_clk later
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         in_q <= 1'b0;
      end else if (init_now) begin
         in_q <= init_cfg.in_init_set;
      end else if (config_done_q && in_en) begin
         if (cfg_q.in_latch_mode) begin
            if (ick) begin
               in_q <= in_d;
            end
         end else if (ick_rise) begin
            in_q <= in_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // routed input taps
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         route_a_q <= 1'b0;
      end else begin
         route_a_q <= cfg_q.route_a_registered ? in_q : delayed_pad;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         route_b_q <= 1'b0;
      end else begin
         route_b_q <= cfg_q.route_b_registered ? in_q : delayed_pad;
      end
   end

   assign routed_input_a = route_a_q;
   assign routed_input_b = route_b_q;

   ////////////////////////////////////////////////////////////////////////////
   // output path
   assign out_d = core_out_data ^ cfg_q.out_invert;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         out_q <= 1'b0;
      end else if (init_now) begin
         out_q <= init_cfg.out_init_set;
      end else if (config_done_q && out_en && ock_rise) begin
         out_q <= out_d;
      end
   end

   // pad driven only after configuration; three-state high wins over all when tristate_connected is set
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pad_out_q <= 1'b0;
      end else begin
         pad_out_q <= cfg_q.out_registered ? out_q : out_d;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pad_oe_q <= 1'b0;
      end else begin
         pad_oe_q <= config_done_q & ~(cfg_q.tristate_connected & core_tristate);
      end
   end

   assign pad_out = pad_out_q;
   assign pad_oe  = pad_oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // status view
   assign status = '{config_done:   config_done_q,
                     pad_level:     delayed_pad,
                     capture_level: capture_q,
                     output_level:  out_q,
                     input_level:   in_q};

endmodule // ioc_register_path

// File: verif/ioc_pad_model.sv
// package pad model facing the i/o cell
`timescale 1ns/100ps
module ioc_pad_model (
   // cell drive
   input  wire logic pad_out,
   input  wire logic pad_oe,
   // external source
   input  wire logic ext_val,
   // level seen by the cell
   output logic      pad_in
);
   // a driving cell wins the pad; released, the outside source shows
   assign pad_in = pad_oe ? pad_out : ext_val;
endmodule // ioc_pad_model

// File: verif/ioc_path_checker_assertions.sv
// port-level assertions for the i/o cell register path
`timescale 1ns/100ps
module ioc_path_checker
   import ioc_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // register bus
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // pad and core
   input wire logic        pad_in,
   input wire logic        input_side_clock,
   input wire logic        output_side_clock,
   input wire logic        global_init_pulse,
   input wire logic        storage_clock_enable,
   input wire logic        core_out_data,
   input wire logic        core_tristate,
   input wire logic        pad_out,
   input wire logic        pad_oe,
   input wire logic        routed_input_a,
   input wire logic        routed_input_b
);
   ////////////////////////////////////////
   // twelve calm cycles cover sync, taps, capture, storage and routing
   logic [7:0] stim_q;
   logic [3:0] quiet_q;
   wire  [7:0] stim = {pad_in, input_side_clock, output_side_clock, global_init_pulse,
                       storage_clock_enable, core_out_data, core_tristate, avs_write};

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stim_q  <= 8'h00;
         quiet_q <= 4'h0;
      end else begin
         stim_q  <= stim;
         quiet_q <= (stim != stim_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
      end
   end

   ////////////////////////////////////////
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   wait_first_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
      else $error("request accepted without a wait cycle");
   ack_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address != IOC_CFG_OFS
      && avs_address != IOC_STATUS_OFS |-> avs_readdata == 32'h0)
      else $error("unmapped or command read not zero");
   oe_reset_a: assert property ($fell(rst) |-> !pad_oe [*3])
      else $error("pad driven before configuration");
   routed_reset_a: assert property ($fell(rst) |-> !routed_input_a && !routed_input_b)
      else $error("routed inputs not cleared by reset");
   input_hold_a: assert property (quiet_q >= 4'hc |-> $stable(routed_input_a) && $stable(routed_input_b))
      else $error("routed input moved with all causes steady");
   output_hold_a: assert property (quiet_q >= 4'hc |-> $stable(pad_out) && $stable(pad_oe))
      else $error("pad output moved with all causes steady");
endmodule // ioc_path_checker

bind ioc_register_path ioc_path_checker chk_u (
   .ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .pad_in,
   .input_side_clock, .output_side_clock, .global_init_pulse, .storage_clock_enable, .core_out_data,
   .core_tristate, .pad_out, .pad_oe, .routed_input_a, .routed_input_b);

// File: verif/tb.sv
// self-checking bench for the i/o cell register path
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("mismatch at %0t got %h expected %h", $time, a, b); end end
`define ST(f, e) begin rd_st(s); `CHK(s.f, e) end
module tb
   import ioc_pkg::*;
;
   logic           ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0]     avs_address = 4'h0;
   logic [31:0]    avs_writedata = 32'h0, avs_readdata;
   logic           input_side_clock = 1'b0, output_side_clock = 1'b0, global_init_pulse = 1'b0;
   logic           core_out_data = 1'b0, core_tristate = 1'b1, storage_clock_enable = 1'b0, ext_val = 1'b0;
   logic           avs_waitrequest, pad_in, pad_out, pad_oe, routed_input_a, routed_input_b;
   int             fail_count = 0;
   int             total_checks = 0;
   ioc_cfg_type    c;
   ioc_status_type s;

   always #5 ref_clk = ~ref_clk;

   ioc_register_path dut_u (
      .ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
      .avs_readdata, .avs_waitrequest, .pad_in, .input_side_clock, .output_side_clock, .global_init_pulse,
      .pad_out, .pad_oe, .core_out_data, .core_tristate, .storage_clock_enable, .routed_input_a,
      .routed_input_b);
   ioc_pad_model pad_u (.pad_out, .pad_oe, .ext_val, .pad_in);

   ////////////////////////////////////////
   task print_verdict;
      if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         fail_count++;
         print_verdict;
      end else begin
         r = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask

   task rd_st(output ioc_status_type v);
      logic [31:0] r;
      bus(1'b0, IOC_STATUS_OFS, 32'h0, r);
      v = r[4:0];
   endtask

   task commit;
      logic [31:0] r;
      bus(1'b1, IOC_CFG_OFS, {13'h0, c}, r);
      bus(1'b1, IOC_CMD_OFS, 32'h1, r);
      repeat (6) @(posedge ref_clk);
   endtask

   // pin levels held six cycles, three times the two-stage sync
   task pin(input logic o, input logic v);
      @(posedge ref_clk);
      if (o) output_side_clock <= v;
      else input_side_clock <= v;
      repeat (6) @(posedge ref_clk);
   endtask

   task pad(input logic v);
      @(posedge ref_clk);
      ext_val <= v;
      repeat (6) @(posedge ref_clk);
   endtask

   // input tests keep the cell off the pad
   task clr;
      c = '0;
      c.tristate_connected = 1'b1;
   endtask

   ////////////////////////////////////////
   task t_reset;
      logic [31:0] r;
      bus(1'b0, IOC_CFG_OFS, 32'h0, r);
      `CHK(r, {13'h0, IOC_CFG_RESET})
      bus(1'b0, 4'hc, 32'h0, r);
      `CHK(r, 32'h0)
      `ST(config_done, 1'b0)
      `CHK(pad_oe, 1'b0)
   endtask

   task t_flop;
      clr;
      c.route_a_registered = 1'b1;
      c.in_init_set = 1'b1;
      commit;
      `ST(input_level, 1'b1)
      pin(0, 1);
      `ST(input_level, 1'b0)
      pad(1);
      `CHK(routed_input_b, 1'b1)
      `CHK(routed_input_a, 1'b0)
      pin(0, 0);
      c.enable_connected = 1'b1;
      c.enable_to_input = 1'b1;
      commit;
      pad(0);
      pin(0, 1);
      `ST(input_level, 1'b1)
      pin(0, 0);
      storage_clock_enable <= 1'b1;
      pin(0, 1);
      `ST(input_level, 1'b0)
      pin(0, 0);
      c.enable_to_input = 1'b0;
      commit;
      storage_clock_enable <= 1'b0;
      pin(0, 1);
      `ST(input_level, 1'b0)
      pin(0, 0);
   endtask

   task t_inv;
      clr;
      c.in_clk_invert = 1'b1;
      commit;
      pad(1);
      pin(0, 1);
      `ST(input_level, 1'b0)
      pin(0, 0);
      `ST(input_level, 1'b1)
      clr;
      c.in_latch_mode = 1'b1;
      commit;
      pin(0, 1);
      `ST(input_level, 1'b1)
      pad(0);
      `ST(input_level, 1'b0)
      pin(0, 0);
      pad(1);
      `ST(input_level, 1'b0)
   endtask

   task t_out;
      clr;
      c.out_registered = 1'b1;
      c.out_invert = 1'b1;
      commit;
      core_tristate <= 1'b0;
      pin(1, 1);
      `CHK(pad_out, 1'b1)
      `CHK(pad_oe, 1'b1)
      core_out_data <= 1'b1;
      core_tristate <= 1'b1;
      repeat (4) @(posedge ref_clk);
      `CHK(pad_out, 1'b1)
      `CHK(pad_oe, 1'b0)
      pin(1, 0);
      c.tristate_connected = 1'b0;
      c.out_registered = 1'b0;
      commit;
      `CHK(pad_oe, 1'b1)
      `CHK(pad_out, 1'b0)
      c.out_registered = 1'b1;
      c.out_clk_invert = 1'b1;
      commit;
      core_out_data <= 1'b0;
      pin(1, 1);
      `CHK(pad_out, 1'b0)
      pin(1, 0);
      `CHK(pad_out, 1'b1)
   endtask

   task t_init;
      logic [31:0] r;
      clr;
      c.in_init_set = 1'b1;
      c.out_init_set = 1'b1;
      c.out_registered = 1'b1;
      c.enable_connected = 1'b1;
      c.enable_to_input = 1'b1;
      c.enable_to_output = 1'b1;
      commit;
      `CHK(pad_out, 1'b1)
      storage_clock_enable <= 1'b1;
      core_out_data <= 1'b0;
      pad(0);
      pin(0, 1);
      pin(1, 1);
      `ST(input_level, 1'b0)
      `CHK(pad_out, 1'b0)
      storage_clock_enable <= 1'b0;
      global_init_pulse <= 1'b1;
      repeat (6) @(posedge ref_clk);
      global_init_pulse <= 1'b0;
      `ST(input_level, 1'b1)
      `CHK(pad_out, 1'b1)
      pin(0, 0);
      pin(1, 0);
      storage_clock_enable <= 1'b1;
      pin(0, 1);
      `ST(input_level, 1'b0)
      bus(1'b1, IOC_CMD_OFS, 32'h2, r);
      `ST(input_level, 1'b1)
      pin(0, 0);
   endtask

   // closed capture latch hides the pad; round two uses latch storage and an inverted capture clock
   task t_cap;
      for (int i = 0; i < 2; i++) begin
         clr;
         c.enhanced = 1'b1;
         c.capture_enable = 1'b1;
         c.capture_clk_invert = i[0];
         c.in_latch_mode = i[0];
         commit;
         pin(1, !i[0]);
         pad(1);
         pin(0, 1);
         `ST(input_level, 1'b0)
         pin(0, 0);
         pin(1, i[0]);
         pin(0, 1);
         `ST(input_level, 1'b1)
         pin(0, 0);
         pin(1, 1'b0);
         pad(0);
      end
   endtask

   // pad edge to routed_input_b: two sync stages, taps, routing flop; taps skip 0, partial 1, full 2, base 1
   task t_delay;
      int d;
      for (int i = 0; i < 4; i++) begin
         clr;
         c.enhanced = (i != 3);
         c.delay_select = (i == 1) ? IOC_DELAY_PARTIAL : IOC_DELAY_FULL;
         c.skip_input_delay = (i == 0);
         d = (i == 2) ? 2 : (i == 0) ? 0 : 1;
         commit;
         pad(0);
         ext_val <= 1'b1;
         repeat (2 + d) @(posedge ref_clk);
         @(negedge ref_clk);
         `CHK(routed_input_b, 1'b0)
         @(negedge ref_clk);
         `CHK(routed_input_b, 1'b1)
      end
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_flop;
      t_inv;
      t_out;
      t_init;
      t_cap;
      t_delay;
      print_verdict;
   end
endmodule // tb
